// ==== rtl/fiber_ring_defs.svh ====
// shared timing counts, switch positions and reset values for the fiber ring fault manager
`ifndef FIBER_RING_DEFS_SVH
`define FIBER_RING_DEFS_SVH

// configuration bank b switch positions (switch n sits at bit n-1)
`define SW_TRAP_ENABLE 1
`define SW_SIM_FAULT_A 2
`define SW_SIM_FAULT_B 3
`define BANK_WIDTH 8

// receive silence timeout before a channel is declared failed
`define RX_TIMEOUT_US 100
// pushbutton debounce settle time
`define DEBOUNCE_US 10000
// core clock rate in mhz
`define CLK_MHZ 25

// derived cycle counts (longest-wait style figures, at least one cycle)
`define RX_TIMEOUT_CYC (`RX_TIMEOUT_US * `CLK_MHZ)
`define DEBOUNCE_CYC (`DEBOUNCE_US * `CLK_MHZ)

// fault contact open value; the manager loads its inverse at reset, so the contacts reset closed
`define CONTACT_RESET 1'b0

`endif

// ==== rtl/fiber_ring_pkg.sv ====
// types shared by the fiber ring fault manager
package fiber_ring_pkg;

  // per-channel state of the fault logic
  typedef enum logic [3:0] {
    CH_ACTIVE = 4'b0001,
    CH_FAILED = 4'b0010,
    CH_TRAPPED = 4'b0100,
    CH_POWERUP = 4'b1000
  } chan_state_t;

  // receive side inputs of one channel
  typedef struct packed {
    logic rxActivity;
    logic rxDataIn;
  } rx_link_t;

  // transmit side outputs of one channel
  typedef struct packed {
    logic txEnable;
    logic txDataOut;
  } tx_link_t;

endpackage

// ==== rtl/fiber_channel_monitor.sv ====
// receive watchdog for one fiber channel: flags silence that reaches the timeout
`timescale 1ns/1ps
`include "fiber_ring_defs.svh"

module fiber_channel_monitor
  import fiber_ring_pkg::*;
#(
  parameter int TIMEOUT_CYC = `RX_TIMEOUT_CYC
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic rxActivity,
  output logic rxFail
);

  localparam int CW = $clog2(TIMEOUT_CYC + 1);

  logic [CW-1:0] silentCount;
  logic [CW-1:0] next_silentCount;
  logic next_rxFail;

  // count cycles without activity, fail once the timeout is reached
  always_comb
  begin
    next_silentCount = silentCount;
    next_rxFail = rxFail;
    if (rxActivity)
    begin
      next_silentCount = '0;
      next_rxFail = 1'b0;
    end
    else if (silentCount >= CW'(TIMEOUT_CYC - 1))
    begin
      next_rxFail = 1'b1;
    end
    else
    begin
      next_silentCount = silentCount + CW'(1);
    end
  end

  // register the watchdog; a link starts out considered silent
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      silentCount <= '0;
      rxFail <= 1'b1;
    end
    else
    begin
      silentCount <= next_silentCount;
      rxFail <= next_rxFail;
    end
  end

endmodule

// ==== rtl/fiber_ring_fault_manager.sv ====
// fault detect, isolate and trap-and-hold logic for a two-channel fiber ring module
// What this block does
// - a receive failure on channel a or b raises that channel's fault output and silences its transmitter.
// - each fault contact is open with no error and closed while that channel shows an error.
// - in auto-recovery the channel returns to normal by itself once the failure clears.
// - trap mode is chosen on the master module by bank b switch 2.
// - trap mode on the master spreads to every module with no local setting needed.
// - trap mode needs exactly one master, and that master must have trap selected.
// - in trap mode failures are still isolated but held until removed and a reset occurs.
// - after power-up in trap mode both channels may show errors, and bad links latch as failures.
// - a trap reset press on any module returns every trap-mode channel whose failure has cleared to an active error-free state.
// - bank b switch 3 or 4 forces errors on the channel a or b transmit output.
// - with a master selected on a non-redundant network the global error indicator shows error.
// - a non-redundant auto-recovery network works with or without a master.
`timescale 1ns/1ps
`include "fiber_ring_defs.svh"

module fiber_ring_fault_manager
  import fiber_ring_pkg::*;
#(
  parameter int RX_TIMEOUT = `RX_TIMEOUT_CYC,
  parameter int DEBOUNCE = `DEBOUNCE_CYC
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [`BANK_WIDTH-1:0] configBankB,
  input wire logic masterSelect,
  input wire logic redundantRing,
  input wire logic trap_reset_button,
  input wire logic netTrapIn,
  input wire logic netResetIn,
  input wire rx_link_t rxA,
  input wire rx_link_t rxB,
  output tx_link_t txA,
  output tx_link_t txB,
  input wire logic txDataA,
  input wire logic txDataB,
  output logic channel_a_fault_output,
  output logic channel_b_fault_output,
  output logic netTrapOut,
  output logic netResetOut,
  output logic trapModeActive,
  output logic globalError
);

  localparam int DW = $clog2(DEBOUNCE + 1);

  logic [1:0] rxFail;
  logic [1:0] simFault;
  logic [1:0] chanErr;
  logic [1:0] txData;
  logic [1:0] rxAct;
  chan_state_t chState [2];
  chan_state_t next_chState [2];
  logic [DW-1:0] dbCount;
  logic [DW-1:0] next_dbCount;
  logic btnStable;
  logic next_btnStable;
  logic btnPrev;
  logic btnPress;
  logic trapMode;
  logic trapReset;
  tx_link_t next_txA;
  tx_link_t next_txB;
  logic [1:0] next_chanErr;
  logic next_globalError;

  assign rxAct = {rxB.rxActivity, rxA.rxActivity};
  assign txData = {txDataB, txDataA};
  assign simFault = {configBankB[`SW_SIM_FAULT_B], configBankB[`SW_SIM_FAULT_A]};

  // trap mode comes from the local switch on the master, or from the network otherwise
  assign trapMode = masterSelect ? configBankB[`SW_TRAP_ENABLE] : netTrapIn;
  assign netTrapOut = masterSelect & configBankB[`SW_TRAP_ENABLE];
  assign trapModeActive = trapMode;

  // a debounced local press or a press relayed from any module resets the trap
  assign btnPress = btnStable & ~btnPrev;
  assign trapReset = btnPress | netResetIn;
  assign netResetOut = btnPress;

  // one receive watchdog per channel
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_mon
      fiber_channel_monitor #(
        .TIMEOUT_CYC(RX_TIMEOUT)
      ) u_mon (
        .core_clk(core_clk),
        .reset(reset),
        .rxActivity(rxAct[g]),
        .rxFail(rxFail[g])
      );
    end
  endgenerate

  // pushbutton debounce: accept a new level only after it holds for the settle time
  always_comb
  begin
    next_dbCount = '0;
    next_btnStable = btnStable;
    if (trap_reset_button != btnStable)
    begin
      if (dbCount >= DW'(DEBOUNCE - 1))
      begin
        next_btnStable = trap_reset_button;
      end
      else
      begin
        next_dbCount = dbCount + DW'(1);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      dbCount <= '0;
      btnStable <= 1'b0;
      btnPrev <= 1'b0;
    end
    else
    begin
      dbCount <= next_dbCount;
      btnStable <= next_btnStable;
      btnPrev <= btnStable;
    end
  end

  // per-channel fault state machine
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      next_chState[c] = chState[c];
      case (chState[c])
        CH_POWERUP:
        begin
          // trap mode holds the power-up error until a trap reset
          if (trapMode)
          begin
            if (trapReset && !rxFail[c])
            begin
              next_chState[c] = CH_ACTIVE;
            end
          end
          else if (!rxFail[c])
          begin
            next_chState[c] = CH_ACTIVE;
          end
        end
        CH_ACTIVE:
        begin
          if (rxFail[c])
          begin
            next_chState[c] = trapMode ? CH_TRAPPED : CH_FAILED;
          end
        end
        CH_FAILED:
        begin
          if (trapMode)
          begin
            next_chState[c] = CH_TRAPPED;
          end
          else if (!rxFail[c])
          begin
            next_chState[c] = CH_ACTIVE;
          end
        end
        CH_TRAPPED:
        begin
          // needs both the fault gone and a reset, or leaving trap mode
          if (!trapMode)
          begin
            next_chState[c] = rxFail[c] ? CH_FAILED : CH_ACTIVE;
          end
          else if (trapReset && !rxFail[c])
          begin
            next_chState[c] = CH_ACTIVE;
          end
        end
        default:
        begin
          next_chState[c] = CH_POWERUP;
        end
      endcase
    end
  end

  // outputs: fault contacts, transmit gating and simulated faults
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      next_chanErr[c] = (next_chState[c] != CH_ACTIVE);
    end
    // silencing the transmitter makes the neighbour see the same fault
    next_txA.txEnable = ~next_chanErr[0];
    next_txA.txDataOut = next_chanErr[0] ? 1'b0 : (txData[0] ^ simFault[0]);
    next_txB.txEnable = ~next_chanErr[1];
    next_txB.txDataOut = next_chanErr[1] ? 1'b0 : (txData[1] ^ simFault[1]);
    // a master on a non-redundant network always shows global error
    next_globalError = (masterSelect & ~redundantRing) | (|next_chanErr);
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      chState[0] <= CH_POWERUP;
      chState[1] <= CH_POWERUP;
      chanErr <= {2{~`CONTACT_RESET}};
      txA <= '0;
      txB <= '0;
      globalError <= 1'b1;
    end
    else
    begin
      chState[0] <= next_chState[0];
      chState[1] <= next_chState[1];
      chanErr <= next_chanErr;
      txA <= next_txA;
      txB <= next_txB;
      globalError <= next_globalError;
    end
  end

  // contact closes (high) while the channel is in error
  assign channel_a_fault_output = chanErr[0];
  assign channel_b_fault_output = chanErr[1];

endmodule

// ==== tb/fiber_ring_fault_manager_properties.sv ====
// port-level checker for the fiber ring fault manager
`timescale 1ns/1ps
`include "fiber_ring_defs.svh"

module fiber_ring_fault_manager_properties
  import fiber_ring_pkg::*;
#(
  parameter int RX_TIMEOUT = `RX_TIMEOUT_CYC
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [`BANK_WIDTH-1:0] configBankB,
  input wire logic masterSelect,
  input wire logic redundantRing,
  input wire logic netTrapIn,
  input wire logic netResetIn,
  input wire rx_link_t rxA,
  input wire tx_link_t txA,
  input wire tx_link_t txB,
  input wire logic txDataA,
  input wire logic channel_a_fault_output,
  input wire logic channel_b_fault_output,
  input wire logic netTrapOut,
  input wire logic netResetOut,
  input wire logic trapModeActive,
  input wire logic globalError
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  int quietCnt;
  // counts cycles of receive silence on channel a
  always_ff @(posedge core_clk)
  begin
    if (reset || rxA.rxActivity)
      quietCnt <= 0;
    else if (quietCnt < 1000)
      quietCnt <= quietCnt + 1;
  end
  property p_txOff;
    (channel_a_fault_output -> !txA.txEnable) && (channel_b_fault_output -> !txB.txEnable);
  endproperty
  a_txOff: assert property (p_txOff) else $error("transmitter on while channel faulted");
  property p_silence;
    quietCnt >= RX_TIMEOUT + 2 |-> channel_a_fault_output;
  endproperty
  a_silence: assert property (p_silence) else $error("silent channel a not faulted");
  property p_autoClear;
    (!trapModeActive && rxA.rxActivity)[*3] |=> !channel_a_fault_output;
  endproperty
  a_autoClear: assert property (p_autoClear) else $error("auto mode fault did not clear");
  property p_trapHold;
    trapModeActive && channel_a_fault_output && !netResetOut && !netResetIn |=> channel_a_fault_output || !trapModeActive;
  endproperty
  a_trapHold: assert property (p_trapHold) else $error("trapped fault released without reset");
  property p_trapSrc;
    netTrapOut == (masterSelect && configBankB[1]);
  endproperty
  a_trapSrc: assert property (p_trapSrc) else $error("trap broadcast wrong");
  property p_trapSpread;
    trapModeActive == (masterSelect ? configBankB[1] : netTrapIn);
  endproperty
  a_trapSpread: assert property (p_trapSpread) else $error("effective trap mode wrong");
  property p_global;
    masterSelect && !redundantRing |=> globalError;
  endproperty
  a_global: assert property (p_global) else $error("global error missing on open bus master");
  property p_simFault;
    $past(configBankB[2]) && txA.txEnable |-> txA.txDataOut == !$past(txDataA);
  endproperty
  a_simFault: assert property (p_simFault) else $error("simulated fault not forced on channel a");
  property p_resetPulse;
    netResetOut |=> !netResetOut;
  endproperty
  a_resetPulse: assert property (p_resetPulse) else $error("trap reset relay longer than one cycle");
endmodule

bind fiber_ring_fault_manager fiber_ring_fault_manager_properties #(.RX_TIMEOUT(RX_TIMEOUT)) u_props (.core_clk,
  .reset, .configBankB, .masterSelect, .redundantRing, .netTrapIn, .netResetIn, .rxA, .txA, .txB, .txDataA,
  .channel_a_fault_output, .channel_b_fault_output, .netTrapOut, .netResetOut, .trapModeActive, .globalError);

// ==== tb/adjacent_fiber_node.sv ====
// neighbour module model: sends receive activity while its link is intact
`timescale 1ns/1ps

module adjacent_fiber_node
  import fiber_ring_pkg::*;
(
  input wire logic core_clk,
  input wire logic linkOk,
  output rx_link_t rxOut
);
  logic toggle = 1'b0;
  // line data keeps changing even when the link is broken
  always_ff @(posedge core_clk)
    toggle <= ~toggle;
  assign rxOut = '{rxActivity: linkOk, rxDataIn: toggle};
endmodule

// ==== tb/fiber_ring_fault_manager_test.sv ====
// testbench for the fiber ring fault manager
`timescale 1ns/1ps

module fiber_ring_fault_manager_test;
  import fiber_ring_pkg::*;
  logic core_clk, reset, masterSelect, redundantRing, trap_reset_button, netTrapIn, netResetIn;
  logic txDataA, txDataB, linkA, linkB, faultA, faultB, netTrapOut, netResetOut, trapModeActive, globalError;
  logic [7:0] configBankB;
  rx_link_t rxA, rxB;
  tx_link_t txA, txB;
  int err_count = 0;
  int n_checks = 0;
  adjacent_fiber_node nodeA (.core_clk(core_clk), .linkOk(linkA), .rxOut(rxA));
  adjacent_fiber_node nodeB (.core_clk(core_clk), .linkOk(linkB), .rxOut(rxB));
  fiber_ring_fault_manager #(.RX_TIMEOUT(8), .DEBOUNCE(4)) dut (.core_clk(core_clk), .reset(reset),
    .configBankB(configBankB), .masterSelect(masterSelect), .redundantRing(redundantRing),
    .trap_reset_button(trap_reset_button), .netTrapIn(netTrapIn), .netResetIn(netResetIn), .rxA(rxA), .rxB(rxB),
    .txA(txA), .txB(txB), .txDataA(txDataA), .txDataB(txDataB), .channel_a_fault_output(faultA),
    .channel_b_fault_output(faultB), .netTrapOut(netTrapOut), .netResetOut(netResetOut),
    .trapModeActive(trapModeActive), .globalError(globalError));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // step n clock edges, then drive just after the edge
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task chk(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // auto mode: break channel a, then mend it
  task t_auto();
    cyc(4);
    chk("faultA", 1'b0, faultA);
    chk("txA.txEnable", 1'b1, txA.txEnable);
    linkA = 1'b0;
    cyc(12);
    chk("faultA", 1'b1, faultA);
    chk("txA.txEnable", 1'b0, txA.txEnable);
    chk("faultB", 1'b0, faultB);
    linkA = 1'b1;
    cyc(4);
    chk("faultA", 1'b0, faultA);
  endtask
  // fault simulation switches invert transmit data
  task t_sim();
    configBankB = 8'h04;
    txDataA = 1'b1;
    cyc(2);
    chk("txA.txDataOut", 1'b0, txA.txDataOut);
    chk("txA.txEnable", 1'b1, txA.txEnable);
    configBankB = 8'h08;
    cyc(2);
    chk("txB.txDataOut", 1'b1, txB.txDataOut);
    configBankB = 8'h00;
  endtask
  // open bus with and without a master
  task t_global();
    redundantRing = 1'b0;
    masterSelect = 1'b1;
    cyc(2);
    chk("globalError", 1'b1, globalError);
    masterSelect = 1'b0;
    cyc(2);
    chk("globalError", 1'b0, globalError);
    redundantRing = 1'b1;
  endtask
  // single master selects trap mode, failure held until a button press
  task t_trap();
    masterSelect = 1'b1;
    configBankB = 8'h02;
    cyc(1);
    chk("netTrapOut", 1'b1, netTrapOut);
    chk("trapModeActive", 1'b1, trapModeActive);
    linkA = 1'b0;
    cyc(12);
    linkA = 1'b1;
    cyc(6);
    chk("faultA", 1'b1, faultA);
    trap_reset_button = 1'b1;
    cyc(4);
    chk("netResetOut", 1'b1, netResetOut);
    cyc(1);
    chk("netResetOut", 1'b0, netResetOut);
    cyc(5);
    trap_reset_button = 1'b0;
    cyc(2);
    chk("faultA", 1'b0, faultA);
    masterSelect = 1'b0;
    configBankB = 8'h00;
  endtask
  // follower in trap mode powers up failed, relayed reset frees it
  task t_follow();
    netTrapIn = 1'b1;
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    chk("trapModeActive", 1'b1, trapModeActive);
    cyc(4);
    chk("faultB", 1'b1, faultB);
    chk("txB.txEnable", 1'b0, txB.txEnable);
    netResetIn = 1'b1;
    cyc(1);
    netResetIn = 1'b0;
    cyc(2);
    chk("faultA", 1'b0, faultA);
    chk("faultB", 1'b0, faultB);
    chk("txB.txEnable", 1'b1, txB.txEnable);
  endtask
  initial
  begin
    reset = 1'b1;
    configBankB = 8'h00;
    masterSelect = 1'b0;
    redundantRing = 1'b1;
    trap_reset_button = 1'b0;
    netTrapIn = 1'b0;
    netResetIn = 1'b0;
    txDataA = 1'b0;
    txDataB = 1'b0;
    linkA = 1'b1;
    linkB = 1'b1;
    cyc(6);
    reset = 1'b0;
    t_auto();
    t_sim();
    t_global();
    t_trap();
    t_follow();
    end_sim();
  end
  // cut a hang short well beyond the expected run
  initial
  begin
    #(40 * 2000);
    err_count++;
    end_sim();
  end
endmodule
